// >>> bank_addr_pkg.sv
// Constants for the banked data memory address unit.
// Assumes a single core clock and an 8-bit datapath around it.
package bank_addr_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int PTR_COUNT = 3;
	localparam int MEM_DEPTH = 4096;

	// Fast-access window split point and the two banks it draws from.
	localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h60;
	localparam logic [3:0] BANK_ZERO = 4'h0;
	localparam logic [3:0] BANK_SFR = 4'hF;

	// One bit per bank; a set bit means the bank holds memory.
	localparam logic [15:0] BANK_IMPL_MASK = 16'h803F;

	// Bank select register location and its writable bits.
	localparam logic [11:0] BANK_SELECT_ADDR = 12'hFE0;
	localparam logic [7:0] BANK_SELECT_MASK = 8'h0F;
	localparam logic [7:0] BANK_SELECT_RST = 8'h00;

	// Pointer register block in bank 15: seven slots per pointer, counted
	// downward from the base offset, one stride apart per pointer.
	localparam logic [7:0] PTR_BASE_OFF = 8'hEF;
	localparam logic [7:0] PTR_STRIDE = 8'h08;
	localparam logic [7:0] PTR_SLOT_LAST = 8'h06;
	localparam logic [2:0] SLOT_PLAIN = 3'h0;
	localparam logic [2:0] SLOT_POSTINC = 3'h1;
	localparam logic [2:0] SLOT_POSTDEC = 3'h2;
	localparam logic [2:0] SLOT_PREINC = 3'h3;
	localparam logic [2:0] SLOT_OFFSET = 3'h4;
	localparam logic [2:0] SLOT_HIGH = 3'h5;
	localparam logic [2:0] SLOT_LOW = 3'h6;

	localparam logic [11:0] PTR_RST = 12'h000;
	localparam logic [11:0] PTR_STEP = 12'h001;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [3:0] HIGH_PAD = 4'h0;

endpackage

// >>> bank_addr_unit.sv
// Address former and data store for a banked 4096-byte data memory.
// Assumes the instruction decoder presents one operand access per cycle.
//
// How it works
// - Fast window is low 96 bytes of bank 0 plus top 160 of bank 15.
// - Access bit 0 selects fast window; 1 selects bank named by bank_select.
// - Last low window byte is followed directly by first high window byte.
// - Sixteen banks of 256 bytes, offset is the low operand byte.
// - Low four bank_select bits form the upper address nibble.
// - Upper four bank_select bits read zero, writes to them ignored.
// - Unimplemented bank reads zero and discards writes.
// - Core flags still update on unimplemented banks; read data stays valid.
// - Full-address move uses its own 12-bit address, ignoring bank_select.
// - Operand on an alias location accesses where the pointer points.
// - Each pointer holds a 12-bit linear address.
// - Indirect read of an alias location returns 00h.
// - Indirect write to an alias location stores nothing; the pointer still takes its alias step.
// - Three pointers, each built from a high and a low byte.
// - Five aliases per pointer; offset alias leaves pointer and working_register alone.
// - Pointer steps act on all 12 bits and touch no status flags.
// - A write to a pointer's own byte beats its step.
`timescale 1ns/1ps

module bank_addr_unit
	import bank_addr_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic acc_valid_i,
	input wire logic acc_write_i,
	input wire logic [7:0] op_addr_i,
	input wire logic access_bit_i,
	input wire logic full_move_i,
	input wire logic [11:0] full_addr_i,
	input wire logic [7:0] working_register_i,
	input wire logic [7:0] wr_data_i,
	input wire logic bank_lit_load_i,
	input wire logic [7:0] bank_lit_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic [11:0] eff_addr_o,
	output logic blocked_o,
	output logic [7:0] bank_select_o
);

	////////////////////////////////////////////////////////////////////////////
	// Slot decoding helpers.

	// Returns {hit, slot} for pointer n at address a.
	function automatic logic [3:0] slot_of(input logic [11:0] a, input int n);
		logic [7:0] base;
		logic [7:0] rel;
		base = PTR_BASE_OFF - 8'(n * PTR_STRIDE);
		rel = base - a[7:0];
		slot_of = {1'b0, SLOT_PLAIN};
		if ((a[11:8] == BANK_SFR) && (a[7:0] <= base) && (rel <= PTR_SLOT_LAST)) begin
			slot_of = {1'b1, rel[2:0]};
		end
	endfunction

	// True when a is any alias location of any pointer.
	function automatic logic is_alias(input logic [11:0] a);
		logic [3:0] s;
		is_alias = 1'b0;
		for (int n = 0; n < PTR_COUNT; n++) begin
			s = slot_of(a, n);
			if (s[3] && (s[2:0] <= SLOT_OFFSET)) begin
				is_alias = 1'b1;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State.

	logic [7:0] mem [MEM_DEPTH];
	logic [3:0] bank_select_ff;
	logic [11:0] ptr_ff [PTR_COUNT];
	logic [11:0] nxt_ptr [PTR_COUNT];
	logic [7:0] rd_data_ff;
	logic [7:0] nxt_rd_data;
	logic rd_valid_ff;
	logic [11:0] eff_addr_ff;
	logic blocked_ff;

	////////////////////////////////////////////////////////////////////////////
	// Direct address.

	wire logic in_low_window = op_addr_i < ACCESS_LOW_LIMIT;
	wire logic [3:0] window_bank = in_low_window ? BANK_ZERO : BANK_SFR;
	wire logic [3:0] direct_bank = access_bit_i ? bank_select_ff : window_bank;
	wire logic [11:0] ea_direct = full_move_i ? full_addr_i : {direct_bank, op_addr_i};

	////////////////////////////////////////////////////////////////////////////
	// Indirect address.

	logic dir_hit;
	logic [1:0] dir_n;
	logic [2:0] dir_slot;
	logic [3:0] s_dir;

	always_comb begin
		s_dir = 4'h0;
		dir_hit = 1'b0;
		dir_n = 2'h0;
		dir_slot = SLOT_PLAIN;
		for (int n = 0; n < PTR_COUNT; n++) begin
			s_dir = slot_of(ea_direct, n);
			if (s_dir[3] && (s_dir[2:0] <= SLOT_OFFSET)) begin
				dir_hit = 1'b1;
				dir_n = 2'(n);
				dir_slot = s_dir[2:0];
			end
		end
	end

	wire logic [11:0] ptr_sel = ptr_ff[dir_n];
	wire logic [11:0] working_register_sext = {{4{working_register_i[7]}}, working_register_i};
	wire logic [11:0] ind_ea = (dir_slot == SLOT_PREINC) ? ptr_sel + PTR_STEP :
		(dir_slot == SLOT_OFFSET) ? ptr_sel + working_register_sext : ptr_sel;
	wire logic is_ind = dir_hit;
	wire logic [11:0] ea_final = is_ind ? ind_ea : ea_direct;

	////////////////////////////////////////////////////////////////////////////
	// Target decode and blocking.

	wire logic ind_on_alias = is_ind && is_alias(ind_ea);
	wire logic bank_missing = !BANK_IMPL_MASK[ea_final[11:8]];
	wire logic blocked = ind_on_alias || bank_missing;
	wire logic bsr_hit = ea_final == BANK_SELECT_ADDR;

	logic ptr_hit;
	logic [1:0] ptr_n;
	logic ptr_hi;
	logic [3:0] s_fin;

	always_comb begin
		s_fin = 4'h0;
		ptr_hit = 1'b0;
		ptr_n = 2'h0;
		ptr_hi = 1'b0;
		for (int n = 0; n < PTR_COUNT; n++) begin
			s_fin = slot_of(ea_final, n);
			if (s_fin[3] && ((s_fin[2:0] == SLOT_HIGH) || (s_fin[2:0] == SLOT_LOW))) begin
				ptr_hit = 1'b1;
				ptr_n = 2'(n);
				ptr_hi = s_fin[2:0] == SLOT_HIGH;
			end
		end
	end

	wire logic wr_en = acc_valid_i && acc_write_i && !blocked;
	wire logic mem_wr = wr_en && !bsr_hit && !ptr_hit;
	wire logic [11:0] ptr_tgt = ptr_ff[ptr_n];
	wire logic [7:0] ptr_byte = ptr_hi ? {HIGH_PAD, ptr_tgt[11:8]} : ptr_tgt[7:0];
	wire logic [7:0] bsr_read = {HIGH_PAD, bank_select_ff};

	always_comb begin
		nxt_rd_data = mem[ea_final];
		if (blocked) begin
			nxt_rd_data = READ_ZERO;
		end else if (bsr_hit) begin
			nxt_rd_data = bsr_read;
		end else if (ptr_hit) begin
			nxt_rd_data = ptr_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pointer next state.

	always_comb begin
		for (int n = 0; n < PTR_COUNT; n++) begin
			nxt_ptr[n] = ptr_ff[n];
			if (wr_en && ptr_hit && (ptr_n == 2'(n))) begin
				if (ptr_hi) begin
					nxt_ptr[n] = {wr_data_i[3:0], ptr_ff[n][7:0]};
				end else begin
					nxt_ptr[n] = {ptr_ff[n][11:8], wr_data_i};
				end
			end else if (acc_valid_i && is_ind && (dir_n == 2'(n))) begin
				if ((dir_slot == SLOT_POSTINC) || (dir_slot == SLOT_PREINC)) begin
					nxt_ptr[n] = ptr_ff[n] + PTR_STEP;
				end else if (dir_slot == SLOT_POSTDEC) begin
					nxt_ptr[n] = ptr_ff[n] - PTR_STEP;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bank_select_ff <= BANK_SELECT_RST[3:0];
		end else if (bank_lit_load_i) begin
			bank_select_ff <= bank_lit_i[3:0] & BANK_SELECT_MASK[3:0];
		end else if (wr_en && bsr_hit) begin
			bank_select_ff <= wr_data_i[3:0] & BANK_SELECT_MASK[3:0];
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int n = 0; n < PTR_COUNT; n++) begin
				ptr_ff[n] <= PTR_RST;
			end
		end else begin
			for (int n = 0; n < PTR_COUNT; n++) begin
				ptr_ff[n] <= nxt_ptr[n];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (mem_wr) begin
			mem[ea_final] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_data_ff <= READ_ZERO;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= acc_valid_i && !acc_write_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			eff_addr_ff <= PTR_RST;
		end else begin
			eff_addr_ff <= ea_final;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			blocked_ff <= 1'b0;
		end else begin
			blocked_ff <= acc_valid_i && blocked;
		end
	end

	assign rd_data_o = rd_data_ff;
	assign rd_valid_o = rd_valid_ff;
	assign eff_addr_o = eff_addr_ff;
	assign blocked_o = blocked_ff;
	assign bank_select_o = {HIGH_PAD, bank_select_ff};

endmodule // bank_addr_unit

// >>> bank_addr_chk.sv
// Port checker for the banked address unit.
// Assumes it is bound to each instance of the unit.
`timescale 1ns/1ps
module bank_addr_chk
	import bank_addr_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic acc_valid_i,
	input wire logic acc_write_i,
	input wire logic [7:0] op_addr_i,
	input wire logic access_bit_i,
	input wire logic full_move_i,
	input wire logic [11:0] full_addr_i,
	input wire logic bank_lit_load_i,
	input wire logic [7:0] bank_lit_i,
	input wire logic [7:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic [11:0] eff_addr_o,
	input wire logic blocked_o,
	input wire logic [7:0] bank_select_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);
	wire direct_w = acc_valid_i && !full_move_i;
	sequence s_read;
		acc_valid_i && !acc_write_i;
	endsequence
	sequence s_fast;
		direct_w && !access_bit_i;
	endsequence
	sequence s_bank;
		direct_w && access_bit_i && bank_select_o[3:0] != BANK_SFR;
	endsequence
	sequence s_empty;
		s_bank ##0 !BANK_IMPL_MASK[bank_select_o[3:0]];
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	chk_read_answer: assert property (s_read |=> rd_valid_o)
		else $error("read gave no answer");
	chk_no_stray: assert property (!(acc_valid_i && !acc_write_i) |=> !rd_valid_o)
		else $error("answer without read");
	chk_bank_upper: assert property (bank_select_o[7:4] == 4'h0)
		else $error("bank select upper bits set");
	chk_bank_load: assert property (bank_lit_load_i
		|=> bank_select_o == ($past(bank_lit_i) & 8'h0F))
		else $error("bank literal not loaded");
	chk_fast_low: assert property (s_fast ##0 op_addr_i < ACCESS_LOW_LIMIT
		|=> eff_addr_o == {BANK_ZERO, $past(op_addr_i)})
		else $error("low window address wrong");
	chk_fast_high: assert property (s_fast ##0 op_addr_i >= ACCESS_LOW_LIMIT
		&& op_addr_i < 8'hD8 |=> eff_addr_o == {BANK_SFR, $past(op_addr_i)})
		else $error("high window address wrong");
	chk_banked_addr: assert property (s_bank
		|=> {4'h0, eff_addr_o} == {$past(bank_select_o), $past(op_addr_i)})
		else $error("banked address wrong");
	chk_full_move: assert property (acc_valid_i && full_move_i
		&& full_addr_i[11:8] != BANK_SFR |=> eff_addr_o == $past(full_addr_i))
		else $error("full move address wrong");
	chk_unimpl_bank: assert property (s_empty
		|=> blocked_o && (!rd_valid_o || rd_data_o == READ_ZERO))
		else $error("empty bank not blocked");
	chk_empty_answer: assert property (s_empty ##0 !acc_write_i
		|=> rd_valid_o && rd_data_o == READ_ZERO)
		else $error("empty bank read gave no zero answer");
endmodule // bank_addr_chk

bind bank_addr_unit bank_addr_chk u_bank_addr_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
	.acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .op_addr_i(op_addr_i),
	.access_bit_i(access_bit_i), .full_move_i(full_move_i), .full_addr_i(full_addr_i),
	.bank_lit_load_i(bank_lit_load_i), .bank_lit_i(bank_lit_i), .rd_data_o(rd_data_o),
	.rd_valid_o(rd_valid_o), .eff_addr_o(eff_addr_o), .blocked_o(blocked_o),
	.bank_select_o(bank_select_o));

// >>> core_model.sv
// Decoder stand-in that issues operand accesses and bank loads.
// Assumes one caller at a time on a free-running core clock.
`timescale 1ns/1ps
module core_model (
	input wire logic clk_sys_i,
	output logic vld_o,
	output logic wr_o,
	output logic [7:0] op_o,
	output logic abit_o,
	output logic fm_o,
	output logic [11:0] fa_o,
	output logic [7:0] working_register_o,
	output logic [7:0] wd_o,
	output logic ld_o,
	output logic [7:0] lit_o
);
	initial {vld_o, wr_o, op_o, abit_o, fm_o, fa_o, working_register_o, wd_o, ld_o, lit_o} = '0;
	////////////////////////////////////////////////////////////////////////////////
	// Access bit per operand.
	task automatic acc(input logic w, input logic [1:0] m, input logic [11:0] a,
		input logic [7:0] d, input logic [7:0] r);
		@(posedge clk_sys_i);
		vld_o <= 1'b1;
		wr_o <= w;
		op_o <= a[7:0];
		abit_o <= (m == 2'h1);
		fm_o <= (m == 2'h2);
		fa_o <= a;
		wd_o <= d;
		working_register_o <= r;
		@(posedge clk_sys_i);
		vld_o <= 1'b0;
		wd_o <= ~d;
	endtask
	task automatic lb(input logic [7:0] v);
		@(posedge clk_sys_i);
		ld_o <= 1'b1;
		lit_o <= v;
		@(posedge clk_sys_i);
		ld_o <= 1'b0;
		lit_o <= ~v;
	endtask
endmodule // core_model

// >>> banked_data_memory_addressing_test.sv
// Self-checking bench for the banked address unit.
// Assumes the core model drives every unit input except clk_sys_i and sys_rst_i, which the bench drives.
`timescale 1ns/1ps
module banked_data_memory_addressing_test;
	import bank_addr_pkg::*;
	localparam logic [1:0] MF = 2'h0;
	localparam logic [1:0] MB = 2'h1;
	localparam logic [1:0] MM = 2'h2;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic vld, wr, abit, fm, ld, rvld, blk;
	logic [7:0] op, working_register, wd, lit, rdat, bsel, d, e;
	logic [11:0] fa, eff;
	logic [7:0] v [16];
	logic [7:0] exp_q [$];
	int n_mismatch = 0;
	int cmp_count = 0;
	int seed = 40593;
	int cyc = 0;
	always #2 clk_sys_i = ~clk_sys_i;
	core_model u_core_model (.clk_sys_i(clk_sys_i), .vld_o(vld), .wr_o(wr), .op_o(op),
		.abit_o(abit), .fm_o(fm), .fa_o(fa), .working_register_o(working_register), .wd_o(wd), .ld_o(ld), .lit_o(lit));
	bank_addr_unit u_bank_addr_unit (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.acc_valid_i(vld), .acc_write_i(wr), .op_addr_i(op), .access_bit_i(abit),
		.full_move_i(fm), .full_addr_i(fa), .working_register_i(working_register), .wr_data_i(wd),
		.bank_lit_load_i(ld), .bank_lit_i(lit), .rd_data_o(rdat), .rd_valid_o(rvld),
		.eff_addr_o(eff), .blocked_o(blk), .bank_select_o(bsel));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [11:0] s, input logic [11:0] w);
		cmp_count++;
		if (s !== w) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, w);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic rd(input logic [1:0] m, input logic [11:0] a, input logic [7:0] x,
		input logic [7:0] r = 8'h00);
		exp_q.push_back(x);
		u_core_model.acc(1'b0, m, a, 8'h00, r);
	endtask
	task automatic wt(input logic [1:0] m, input logic [11:0] a, input logic [7:0] x);
		u_core_model.acc(1'b1, m, a, x, 8'h00);
	endtask
	task automatic setp(input logic [11:0] h, input logic [11:0] p);
		wt(MM, h, {4'h0, p[11:8]});
		wt(MM, h - 12'h001, p[7:0]);
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (rvld === 1'b1) begin
			e = exp_q.pop_front();
			check({4'h0, rdat}, {4'h0, e});
		end
		if (cyc > 2000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		#1 check({4'h0, bsel}, {4'h0, BANK_SELECT_RST});
		for (int b = 0; b < 16; b++) begin
			v[b] = 8'($random(seed));
			u_core_model.lb({4'hA, 4'(b)});
			#1 check({4'h0, bsel}, {8'h00, 4'(b)});
			wt(MB, 12'h010, v[b]);
			rd(MB, 12'h010, BANK_IMPL_MASK[b] ? v[b] : READ_ZERO);
		end
		rd(MF, 12'h010, v[0]);
		rd(MM, 12'hF10, v[15]);
		d = 8'($random(seed));
		wt(MF, 12'h080, d);
		rd(MM, 12'hF80, d);
		wt(MF, 12'h05F, v[5]);
		wt(MF, 12'h060, v[6]);
		rd(MM, 12'h05F, v[5]);
		rd(MM, 12'hF60, v[6]);
		setp(12'hFEA, 12'h1FF);
		wt(MM, 12'h1FF, d);
		rd(MF, 12'h0EF, d);
		rd(MF, 12'h0EE, d);
		#1 check(eff, 12'h1FF);
		rd(MM, 12'hFEA, 8'h02);
		rd(MM, 12'hFE9, 8'h00);
		wt(MM, 12'h200, v[1]);
		wt(MF, 12'h0EC, v[2]);
		rd(MM, 12'h201, v[2]);
		rd(MB, 12'h0EB, v[1], 8'hFF);
		#1 check(eff, 12'h200);
		rd(MF, 12'h0ED, v[2]);
		rd(MM, 12'hFE9, 8'h00);
		setp(12'hFEA, 12'hFEF);
		rd(MF, 12'h0EF, READ_ZERO);
		wt(MF, 12'h0EF, d);
		#1 check({11'h000, blk}, 12'h001);
		rd(MM, 12'hFE9, 8'hEF);
		setp(12'hFEA, 12'hFE9);
		wt(MF, 12'h0EE, 8'h55);
		rd(MM, 12'hFE9, 8'h55);
		setp(12'hFE2, 12'h3F0);
		setp(12'hFDA, 12'h305);
		wt(MF, 12'h0E7, v[3]);
		wt(MF, 12'h0DF, v[4]);
		rd(MM, 12'h3F0, v[3]);
		rd(MM, 12'h305, v[4]);
		rd(MM, 12'hFE9, 8'h55);
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		#1 check({4'h0, bsel}, {4'h0, BANK_SELECT_RST});
		rd(MM, 12'hFDA, 8'h00);
		rd(MM, 12'h305, v[4]);
		repeat (3) @(posedge clk_sys_i);
		check(12'(exp_q.size()), 12'h000);
		wrap_up();
	end
endmodule // banked_data_memory_addressing_test
